//--- design/asr_pkg.sv
// constants, field layouts and carrier types for the status/mode register bank
// assumes a single 20 MHz core clock; the serial link is sampled, not clocked
//
// Summary of operation
// - status register is eight bits, read only
// - status shifts out most significant bit first
// - not-ready flag falls when result is written
// - not-ready rises after data read or before update
// - power-down forces not-ready flag high
// - output pin mirrors not-ready flag between transfers
// - clamp flag updated with result, set if clamped
// - conversion-starting write clears clamp flag
// - status bits five, four zero; three one
// - status bit two is fixed variant flag
// - status bits one, zero show channel code
// - reset: not-ready high, clamp low, channel zero
// - mode register is eight bits, read/write, msb first
// - mode selected by code 01, resets 0x02
// - mode layout: op mode, burnout, coding, buffer
// - mode write restarts converter, raises not-ready
// - op mode: continuous, reserved, single, power-down
// - command bit three: zero write, one read
// - command bits five, four select register
package asr_pkg;

    // -----------------------------------------------------------------
    // register select codes
    // -----------------------------------------------------------------
    localparam logic [1:0] RS_STATUS = 2'h0;    // status on read, command on write
    localparam logic [1:0] RS_MODE   = 2'h1;    // operating_config
    localparam logic [1:0] RS_FILTER = 2'h2;    // not served by this bank
    localparam logic [1:0] RS_DATA   = 2'h3;    // not served by this bank

    // -----------------------------------------------------------------
    // command word fields
    // -----------------------------------------------------------------
    localparam int CMD_RS_HI = 5;               // register_select msb
    localparam int CMD_RS_LO = 4;               // register_select lsb
    localparam int CMD_RW    = 3;               // 1 = read next
    localparam int CMD_CH_HI = 1;               // channel_select msb
    localparam int CMD_CH_LO = 0;               // channel_select lsb

    // -----------------------------------------------------------------
    // operating_mode_field codes
    // -----------------------------------------------------------------
    localparam logic [1:0] OPM_CONT   = 2'h0;   // continuous conversion
    localparam logic [1:0] OPM_RSVD   = 2'h1;   // reserved
    localparam logic [1:0] OPM_SINGLE = 2'h2;   // single conversion
    localparam logic [1:0] OPM_PDOWN  = 2'h3;   // power-down

    // -----------------------------------------------------------------
    // reset values and masks
    // -----------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h02;  // only buffer enable set
    localparam logic [7:0] MODE_MASK  = 8'hce;  // bits 5,4,0 held at zero
    localparam logic [1:0] CHAN_RESET = 2'h0;   // channel code after reset
    localparam logic [2:0] BIT_LAST   = 3'h7;   // eighth bit of a byte

    // -----------------------------------------------------------------
    // carrier types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic       rdy_n;      // result_not_ready
        logic       err;        // clamp_error
        logic [1:0] zero;       // always zero
        logic       one;        // always one
        logic       variant;    // variant_flag
        logic [1:0] chan;       // channel_select
    } asr_status_t;

    typedef struct packed {
        logic [1:0] op_mode;    // operating_mode_field
        logic [1:0] zero_hi;    // held zero
        logic       burnout;    // burnout_enable
        logic       unipolar;   // unipolar coding
        logic       buf_en;     // input_buffer_enable
        logic       zero_lo;    // held zero
    } asr_mode_t;

endpackage : asr_pkg

//--- design/asr_sync.sv
// two-stage synchroniser for a group of pin inputs
// assumes the pins are asynchronous to i_clk
`timescale 1ns/10ps
module asr_sync #(
    parameter int         W      = 3,           // number of pins
    parameter logic [W-1:0] RST_VAL = '1        // idle level of the pins
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    // pins in, synchronised out
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_sync
);

    // -----------------------------------------------------------------
    // stages
    // -----------------------------------------------------------------
    logic [W-1:0] meta;         // first stage, read only by second stage
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    // next values: plain shift through the two stages
    always_comb begin
        next_meta = i_pin;
        next_sync = meta;
    end

    // registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta   <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta   <= next_meta;
            o_sync <= next_sync;
        end
    end

endmodule : asr_sync

//--- design/asr_shift.sv
// eight-bit shift register with bit counter for the serial link
// assumes i_shift is a one-cycle pulse per sampled serial clock edge
`timescale 1ns/10ps
module asr_shift (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // control
    input  wire logic       i_shift,    // take i_din, move word up
    input  wire logic       i_load,     // parallel load, restart count
    input  wire logic       i_clear,    // restart count only
    input  wire logic [7:0] i_load_data,
    input  wire logic       i_din,
    // results
    output logic      [7:0] o_word,     // bits gathered so far
    output logic            o_first,    // no bit taken yet in this byte
    output logic            o_done      // pulse: eighth bit taken
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [2:0] cnt;                    // bits taken in this byte
    logic [2:0] next_cnt;
    logic [7:0] next_word;
    logic       next_done;

    assign o_first = (cnt == 3'h0);

    // next values; load beats clear beats shift
    always_comb begin
        next_word = o_word;
        next_cnt  = cnt;
        next_done = 1'b0;
        if (i_load) begin
            next_word = i_load_data;
            next_cnt  = 3'h0;
        end else if (i_clear) begin
            next_cnt  = 3'h0;
        end else if (i_shift) begin
            next_word = {o_word[6:0], i_din};       // msb first
            next_cnt  = cnt + 3'h1;                 // wraps after eight
            next_done = (cnt == asr_pkg::BIT_LAST);
        end
    end

    // registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_word <= 8'h00;
            cnt    <= 3'h0;
            o_done <= 1'b0;
        end else begin
            o_word <= next_word;
            cnt    <= next_cnt;
            o_done <= next_done;
        end
    end

endmodule : asr_shift

//--- design/asr_regbank.sv
// status and mode register bank behind the three-wire serial link
// assumes sclk idles high; host drives din before each rising sclk edge and
// samples dout on rising edges; sclk period well above a few core cycles
`timescale 1ns/10ps
module asr_regbank #(
    parameter logic VARIANT_FLAG = 1'b0     // arbitrary value, tells variants apart
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // serial pins
    input  wire logic       i_sclk,
    input  wire logic       i_din,
    input  wire logic       i_cs_n,
    output logic            o_dout_rdy,
    output logic            o_dout_oe,
    // converter events
    input  wire logic       i_result_written,   // pulse: data register loaded
    input  wire logic       i_result_clamped,   // with the pulse above
    input  wire logic       i_result_pending,   // pulse: update is imminent
    input  wire logic       i_data_read,        // pulse: data register read
    // converter configuration
    output logic      [1:0] o_operating_mode_field,
    output logic            o_burnout_enable,
    output logic            o_unipolar_coding,
    output logic            o_input_buffer_enable,
    output logic      [1:0] o_channel_select,
    output logic            o_restart           // pulse: reset modulator/filter
);

    // -----------------------------------------------------------------
    // pin synchronisation and edge finding
    // -----------------------------------------------------------------
    logic s_sclk;               // synchronised serial clock
    logic s_din;                // synchronised data in
    logic s_cs_n;               // synchronised chip select
    logic sclk_d;               // previous synchronised clock
    logic next_sclk_d;
    logic rise;                 // rising serial clock seen

    asr_sync #(
        .W       (3),
        .RST_VAL (3'h5)         // sclk high, din low, cs high
    ) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pin   ({i_sclk, i_din, i_cs_n}),
        .o_sync  ({s_sclk, s_din, s_cs_n})
    );

    // edge detect on the second stage only
    always_comb begin
        next_sclk_d = s_sclk;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sclk_d <= 1'b1;
        end else begin
            sclk_d <= next_sclk_d;
        end
    end

    assign rise = s_sclk & ~sclk_d;

    // -----------------------------------------------------------------
    // transfer sequencer
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CMD,                 // gathering a command byte
        ST_WR,                  // gathering a mode byte
        ST_RD                   // shifting a register out
    } asr_state_t;

    asr_state_t  state;
    asr_state_t  next_state;

    logic        shift_en;      // take this bit
    logic        load;          // parallel load for a read
    logic  [7:0] load_data;     // what the read shifts out
    logic  [7:0] word;          // gathered byte
    logic        first;         // no bit yet in this byte
    logic        done;          // byte complete
    logic        cmd_done;      // command byte complete
    logic        mode_wr;       // mode byte complete
    logic  [1:0] cmd_rs;        // register_select of command
    logic        cmd_rd;        // read direction of command

    asr_pkg::asr_status_t status_now;   // live status view
    asr_pkg::asr_mode_t   mode;         // operating_config
    asr_pkg::asr_mode_t   next_mode;

    assign cmd_rs   = word[asr_pkg::CMD_RS_HI:asr_pkg::CMD_RS_LO];
    assign cmd_rd   = word[asr_pkg::CMD_RW];
    assign cmd_done = done & (state == ST_CMD);
    assign mode_wr  = done & (state == ST_WR);

    // first command bit must be zero, else the byte does not start;
    // a one leaves the counter parked at the first bit
    assign shift_en = rise & ~s_cs_n & ((state != ST_CMD) | ~first | ~s_din);

    // read loads happen right after the command byte
    assign load = cmd_done & cmd_rd & ((cmd_rs == asr_pkg::RS_STATUS) |
                                       (cmd_rs == asr_pkg::RS_MODE));

    // snapshot of status or mode for the read; status frozen here
    always_comb begin
        if (cmd_rs == asr_pkg::RS_MODE) begin
            load_data = mode;
        end else begin
            load_data = status_now;
        end
    end

    asr_shift u_shift (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_shift     (shift_en),
        .i_load      (load),
        .i_clear     (s_cs_n),
        .i_load_data (load_data),
        .i_din       (s_din),
        .o_word      (word),
        .o_first     (first),
        .o_done      (done)
    );

    // state decode; filter and data selections are not served here and
    // fall back to waiting for a command
    always_comb begin
        next_state = state;
        case (state)
            ST_CMD: begin
                if (cmd_done) begin
                    if (load) begin
                        next_state = ST_RD;
                    end else if (cmd_rs == asr_pkg::RS_MODE) begin
                        next_state = ST_WR;
                    end
                end
            end
            ST_WR: begin
                if (done) begin
                    next_state = ST_CMD;
                end
            end
            ST_RD: begin
                if (done) begin
                    next_state = ST_CMD;
                end
            end
            default: begin
                next_state = ST_CMD;
            end
        endcase
        // deselect aborts any transfer
        if (s_cs_n) begin
            next_state = ST_CMD;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= ST_CMD;
        end else begin
            state <= next_state;
        end
    end

    // -----------------------------------------------------------------
    // mode register and channel code
    // -----------------------------------------------------------------
    logic [1:0] chan;           // channel_select in use
    logic [1:0] next_chan;
    logic       conv_start;     // write that starts a conversion
    logic       pdown;          // power-down selected
    logic       next_restart;

    // held-zero bits are masked so reads never show stray ones;
    // the host is still expected to write them as zero
    always_comb begin
        next_mode = mode;
        next_chan = chan;
        if (mode_wr) begin
            next_mode = word & asr_pkg::MODE_MASK;
        end
        if (cmd_done) begin
            next_chan = word[asr_pkg::CMD_CH_HI:asr_pkg::CMD_CH_LO];
        end
    end

    // every mode write restarts modulator and filter
    assign next_restart = mode_wr;
    assign pdown        = (mode.op_mode == asr_pkg::OPM_PDOWN);
    assign conv_start   = mode_wr &
                          (word[7:6] != asr_pkg::OPM_PDOWN);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode      <= asr_pkg::MODE_RESET;
            chan      <= asr_pkg::CHAN_RESET;
            o_restart <= 1'b0;
        end else begin
            mode      <= next_mode;
            chan      <= next_chan;
            o_restart <= next_restart;
        end
    end

    // -----------------------------------------------------------------
    // status flags
    // -----------------------------------------------------------------
    logic rdy_n;                // result_not_ready
    logic err;                  // clamp_error
    logic next_rdy_n;
    logic next_err;

    // raising wins over a result in the same cycle: a restart or a
    // power-down makes that result stale anyway
    always_comb begin
        next_rdy_n = rdy_n;
        if (i_result_written) begin
            next_rdy_n = 1'b0;
        end
        if (i_data_read | i_result_pending) begin
            next_rdy_n = 1'b1;
        end
        if (pdown) begin
            next_rdy_n = 1'b1;
        end
        if (mode_wr) begin
            next_rdy_n = 1'b1;
        end
    end

    // clamp flag follows each result; a clamped result beats a clear
    always_comb begin
        next_err = err;
        if (conv_start) begin
            next_err = 1'b0;
        end
        if (i_result_written) begin
            next_err = i_result_clamped | (err & ~conv_start);
            if (!i_result_clamped) begin
                next_err = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdy_n <= 1'b1;
            err   <= 1'b0;
        end else begin
            rdy_n <= next_rdy_n;
            err   <= next_err;
        end
    end

    // live status layout
    always_comb begin
        status_now.rdy_n   = rdy_n;
        status_now.err     = err;
        status_now.zero    = 2'h0;
        status_now.one     = 1'b1;
        status_now.variant = VARIANT_FLAG;
        status_now.chan    = chan;
    end

    // -----------------------------------------------------------------
    // output pin
    // -----------------------------------------------------------------
    logic next_dout;
    logic next_oe;

    // during a read the byte goes out msb first, else the pin shows the
    // ready flag; loaded bit lags the load by one core cycle
    always_comb begin
        if (state == ST_RD) begin
            next_dout = word[7];
        end else begin
            next_dout = rdy_n;
        end
        next_oe = ~s_cs_n;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_dout_rdy <= 1'b1;
            o_dout_oe  <= 1'b0;
        end else begin
            o_dout_rdy <= next_dout;
            o_dout_oe  <= next_oe;
        end
    end

    // configuration straight from the mode and channel flops
    assign o_operating_mode_field = mode.op_mode;
    assign o_burnout_enable       = mode.burnout;
    assign o_unipolar_coding      = mode.unipolar;
    assign o_input_buffer_enable  = mode.buf_en;
    assign o_channel_select       = chan;

endmodule : asr_regbank

//--- tb/asr_regbank_props.sv
// port-level assertions for the status/mode register bank
// assumes one core clock domain with a synchronous active-high reset
`timescale 1ns/10ps
module asr_regbank_props (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_reset,
    // serial pins
    input wire logic       i_sclk,
    input wire logic       i_din,
    input wire logic       i_cs_n,
    input wire logic       o_dout_rdy,
    input wire logic       o_dout_oe,
    // converter events
    input wire logic       i_result_written,
    input wire logic       i_result_clamped,
    input wire logic       i_result_pending,
    input wire logic       i_data_read,
    // configuration
    input wire logic [1:0] o_operating_mode_field,
    input wire logic       o_burnout_enable,
    input wire logic       o_unipolar_coding,
    input wire logic       o_input_buffer_enable,
    input wire logic [1:0] o_channel_select,
    input wire logic       o_restart
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    logic [7:0] cfg;    // mode byte rebuilt from the field outputs
    assign cfg = {o_operating_mode_field, 2'b00, o_burnout_enable, o_unipolar_coding,
                  o_input_buffer_enable, 1'b0};

    // ------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------
    // a stored result with no read, pending or power-down raising the flag in the same cycle
    sequence s_clean_result;
        i_result_written && !i_result_pending && !i_data_read
            && o_operating_mode_field != asr_pkg::OPM_PDOWN;
    endsequence
    // no mode-write raise, pin handed back to the flag
    sequence s_pin_free;
        !o_restart ##1 !o_dout_oe;
    endsequence
    property p_reset_cfg;
        $fell(i_reset) |-> cfg == asr_pkg::MODE_RESET && o_channel_select == 2'h0
            && o_dout_rdy && !o_dout_oe && !o_restart;
    endproperty
    property p_restart_once; o_restart |=> !o_restart; endproperty
    property p_cfg_restart; $changed(cfg) |-> o_restart; endproperty
    property p_pdown_high;
        (o_operating_mode_field == asr_pkg::OPM_PDOWN && !o_dout_oe)[*3] |-> o_dout_rdy;
    endproperty
    property p_result_low; s_clean_result ##1 s_pin_free |-> !o_dout_rdy; endproperty
    property p_raise_high;
        (i_data_read || i_result_pending) ##2 !o_dout_oe |-> o_dout_rdy;
    endproperty
    property p_idle_release; i_cs_n[*4] |-> !o_dout_oe; endproperty
    property p_cfg_hold;
        i_cs_n[*4] |=> $stable(cfg) && $stable(o_channel_select);
    endproperty

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_reset_cfg: assert property (p_reset_cfg)
        else $error("reset values wrong");
    a_restart_once: assert property (p_restart_once)
        else $error("restart longer than one cycle");
    a_cfg_restart: assert property (p_cfg_restart)
        else $error("mode change without restart");
    a_pdown_high: assert property (p_pdown_high)
        else $error("power-down with ready pin low");
    a_result_low: assert property (p_result_low)
        else $error("stored result left pin high");
    a_raise_high: assert property (p_raise_high)
        else $error("read or pending left pin low");
    a_idle_release: assert property (p_idle_release)
        else $error("pin driven while deselected");
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("config changed while deselected");
endmodule : asr_regbank_props

bind asr_regbank asr_regbank_props i_asr_regbank_props (
    .i_clk(i_clk), .i_reset(i_reset), .i_sclk(i_sclk), .i_din(i_din), .i_cs_n(i_cs_n),
    .o_dout_rdy(o_dout_rdy), .o_dout_oe(o_dout_oe), .i_result_written(i_result_written),
    .i_result_clamped(i_result_clamped), .i_result_pending(i_result_pending),
    .i_data_read(i_data_read), .o_operating_mode_field(o_operating_mode_field),
    .o_burnout_enable(o_burnout_enable), .o_unipolar_coding(o_unipolar_coding),
    .o_input_buffer_enable(o_input_buffer_enable),
    .o_channel_select(o_channel_select), .o_restart(o_restart));

//--- tb/asr_host_model.sv
// host-side model of the three-wire serial link
// assumes the core clock is handed in only to pace the serial edges
`timescale 1ns/10ps
module asr_host_model (
    // pacing clock
    input  wire logic i_clk,
    // serial pins
    input  wire logic i_dout_rdy,
    output logic      o_sclk,
    output logic      o_din,
    output logic      o_cs_n
);
    // idle: clock parked high, device deselected
    initial begin
        o_sclk = 1'b1;
        o_din  = 1'b1;
        o_cs_n = 1'b1;
    end

    // one byte msb first, 400 ns period, sampled on the rising edge
    task automatic send(input logic [7:0] tx, output logic [7:0] got);
        for (int i = 7; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_din  = tx[i];
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b1;
            got[i] = i_dout_rdy;
            repeat (4) @(negedge i_clk);
        end
    endtask : send

    // command byte, then optionally one access byte, in one select
    task automatic frame(input logic [7:0] cmd, input logic [7:0] data,
                         input logic two, output logic [7:0] got);
        logic [7:0] junk;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        repeat (4) @(negedge i_clk);
        send(cmd, junk);
        got = junk;
        if (two) send(data, got);
        repeat (8) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_din  = ~o_din;                // a released line keeps no stale level
        repeat (8) @(negedge i_clk);
    endtask : frame
endmodule : asr_host_model

//--- tb/testbench.sv
// self-checking bench for the status/mode register bank
// assumes the host model owns the serial pins; events come from here
`timescale 1ns/10ps
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic VF    = 1'b0;      // arbitrary variant value
    localparam int   LIMIT = 20000;     // run needs about 3000 cycles
    logic       clk, reset, sclk, din, cs_n, dout_rdy, dout_oe;
    logic       written, clamped, pending, data_read;
    logic [1:0] opm, chan;
    logic       bo, uni, buf_en, restart;
    int         bad_count, compares, cycles, restarts;
    logic [7:0] rx;

    asr_regbank #(.VARIANT_FLAG(VF)) i_asr_regbank (
        .i_clk(clk), .i_reset(reset), .i_sclk(sclk), .i_din(din), .i_cs_n(cs_n),
        .o_dout_rdy(dout_rdy), .o_dout_oe(dout_oe), .i_result_written(written),
        .i_result_clamped(clamped), .i_result_pending(pending), .i_data_read(data_read),
        .o_operating_mode_field(opm), .o_burnout_enable(bo), .o_unipolar_coding(uni),
        .o_input_buffer_enable(buf_en), .o_channel_select(chan), .o_restart(restart));
    asr_host_model i_asr_host_model (.i_clk(clk), .i_dout_rdy(dout_rdy),
        .o_sclk(sclk), .o_din(din), .o_cs_n(cs_n));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // cycle ceiling and restart pulse count
    always @(posedge clk) begin
        cycles++;
        if (restart === 1'b1) restarts++;
        if (cycles == LIMIT) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [7:0] st(input logic rdy, input logic err, input logic [1:0] ch);
        return {rdy, err, 2'b00, 1'b1, VF, ch};
    endfunction : st
    // one-cycle converter event, then the pin a few cycles on
    task automatic ev(input logic w, input logic c, input logic p, input logic r,
                      input logic pin);
        @(negedge clk);
        {written, clamped, pending, data_read} = {w, c, p, r};
        @(negedge clk);
        {written, pending, data_read} = 3'h0;
        repeat (3) @(negedge clk);
        check({6'h00, dout_oe, dout_rdy}, {7'h00, pin});
    endtask : ev
    task automatic finish_test;
        if (bad_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check({opm, 2'b00, bo, uni, buf_en, 1'b0}, 8'h02);
        check({6'h00, chan}, 8'h00);
        check({6'h00, dout_oe, dout_rdy}, 8'h01);
        i_asr_host_model.frame(8'h08, 8'h00, 1'b1, rx);
        check(rx, st(1'b1, 1'b0, 2'h0));
        i_asr_host_model.frame(8'h18, 8'h00, 1'b1, rx);
        check(rx, 8'h02);
    endtask : t_reset

    // every op code, with its own channel code in the command
    task automatic t_modes;
        logic [31:0] vals;
        logic [7:0]  v;
        int          r0;
        vals = 32'hca84480e;            // bits 5,4,0 kept zero in each byte
        for (int m = 0; m < 4; m++) begin
            v  = vals[8*m +: 8];
            r0 = restarts;
            i_asr_host_model.frame(8'h10 | 8'(m), v, 1'b1, rx);
            check(8'(restarts - r0), 8'h01);
            check({opm, 2'b00, bo, uni, buf_en, 1'b0}, v);
            check({6'h00, chan}, 8'(m));
            i_asr_host_model.frame(8'h18 | 8'(m), 8'h00, 1'b1, rx);
            check(rx, v);
            i_asr_host_model.frame(8'h08 | 8'(m), 8'h00, 1'b1, rx);
            check(rx, st(1'b1, 1'b0, 2'(m)));
        end
        ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    endtask : t_modes

    // results, clamps, reads, pending and the status write selection
    task automatic t_events;
        i_asr_host_model.frame(8'h11, 8'h02, 1'b1, rx);
        ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        i_asr_host_model.frame(8'h09, 8'h00, 1'b1, rx);
        check(rx, st(1'b0, 1'b1, 2'h1));
        i_asr_host_model.frame(8'h01, 8'h00, 1'b0, rx);
        i_asr_host_model.frame(8'h09, 8'h00, 1'b1, rx);
        check(rx, st(1'b0, 1'b1, 2'h1));
        ev(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        i_asr_host_model.frame(8'h11, 8'h02, 1'b1, rx);
        i_asr_host_model.frame(8'h09, 8'h00, 1'b1, rx);
        check(rx, st(1'b1, 1'b0, 2'h1));
        ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    endtask : t_events

    // ------------------------------------------------------------
    // run
    // ------------------------------------------------------------
    initial begin
        {reset, written, clamped, pending, data_read} = 5'h10;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        t_modes();
        t_events();
        finish_test();
    end
endmodule : testbench
